// ===== cpdpr_pkg.sv
// constants for the codec pll, datapath and serial port register bank
// assumes an apb slave with 32-bit data and one word per register
//
// Functional notes
// RULE_01 - register 5 holds fraction multiplier bits 13 to 6
// RULE_02 - register 6 bits 7 to 2 hold fraction multiplier bits 5 to 0
// RULE_03 - host keeps the fraction multiplier at 9999 or below
// RULE_04 - host writes register 5 then register 6 on every change
// RULE_05 - new fraction reaches the pll only when register 6 is written
// RULE_06 - register 6 bits 1 and 0 read zero; host writes zeros
// RULE_07 - datapath bit 7 picks 48 kHz when clear, 44.1 kHz when set
// RULE_08 - datapath bit 6 enables converter-input dual rate, reset off
// RULE_09 - datapath bit 5 enables playback dual rate, reset off
// RULE_10 - host sets record dual rate equal to playback dual rate
// RULE_11 - datapath bits 4:3 route left: mute, left, right, mono mix
// RULE_12 - datapath bits 2:1 route right: mute, right, left, mono mix
// RULE_13 - host writes zero to datapath bit 0
// RULE_14 - serial bit 7 set drives bit clock pin, clear leaves input
// RULE_15 - serial bit 6 set drives frame clock pin, clear leaves input; with frameOnGpOne set the code drives the gp one pin instead
// RULE_16 - serial bit 5 set floats data output while no valid data
// RULE_17 - serial bit 4 keeps master clocks running through power-down
// RULE_18 - serial bit 2 enables the 3-D effect processing
// RULE_19 - host writes zeros to serial bits 1:0, leaves bit 3 alone; the host model writes bit 3 as zero
// RULE_20 - every register is eight bits, bit 7 most significant
package cpdpr_pkg;
  localparam int REG_W = 8;
  localparam int FRAC_W = 14;
  localparam int IDX_W = 4;
  localparam logic [IDX_W-1:0] IDX_FRAC_HIGH = 4'h5;
  localparam logic [IDX_W-1:0] IDX_FRAC_LOW = 4'h6;
  localparam logic [IDX_W-1:0] IDX_DATAPATH = 4'h7;
  localparam logic [IDX_W-1:0] IDX_SERIAL_A = 4'h8;
  localparam logic [REG_W-1:0] RST_FRAC_HIGH = 8'h00;
  localparam logic [REG_W-1:0] RST_FRAC_LOW = 8'h00;
  localparam logic [REG_W-1:0] RST_DATAPATH = 8'h00;
  localparam logic [REG_W-1:0] RST_SERIAL_A = 8'h00;
  localparam logic [FRAC_W-1:0] RST_FRACTION = 14'h0000;
  localparam logic [FRAC_W-1:0] FRAC_MAX = 14'd9999;
  localparam int FRAC_LOW_LSB = 2;
  localparam logic [REG_W-1:0] FRAC_LOW_MASK = 8'hFC;
  localparam int DP_FSREF_BIT = 7;
  localparam int DP_ADC_DUAL_BIT = 6;
  localparam int DP_DAC_DUAL_BIT = 5;
  localparam int DP_LEFT_MSB = 4;
  localparam int DP_LEFT_LSB = 3;
  localparam int DP_RIGHT_MSB = 2;
  localparam int DP_RIGHT_LSB = 1;
  localparam int SP_BIT_MASTER_BIT = 7;
  localparam int SP_FRAME_MASTER_BIT = 6;
  localparam int SP_DOUT_FLOAT_BIT = 5;
  localparam int SP_KEEP_CLK_BIT = 4;
  localparam int SP_EFFECT3D_BIT = 2;
  localparam logic [31:0] RDATA_NONE = 32'h0000_0000;

  typedef enum logic [1:0] {
    ROUTE_MUTE = 2'b00,
    ROUTE_SAME = 2'b01,
    ROUTE_OTHER = 2'b10,
    ROUTE_MONO = 2'b11
  } cpdpr_route_t;

  function automatic logic [31:0] byteAddr(input logic [IDX_W-1:0] idx);
    byteAddr = {26'h000_0000, idx, 2'b00};
  endfunction : byteAddr
endpackage : cpdpr_pkg

// ===== cpdpr_reg_if.sv
// register access strobes between the apb slave and the register bank
// assumes one clock shared by both ends
`timescale 1ns/1ps
interface cpdpr_reg_if;
  import cpdpr_pkg::*;
  logic wrEn;
  logic [IDX_W-1:0] wrIdx;
  logic [REG_W-1:0] wrData;
  logic [IDX_W-1:0] rdIdx;
  logic [REG_W-1:0] rdData;
  logic hit;

  modport bus
  (
    output wrEn,
    output wrIdx,
    output wrData,
    output rdIdx,
    input rdData,
    input hit
  );
  modport bank
  (
    input wrEn,
    input wrIdx,
    input wrData,
    input rdIdx,
    output rdData,
    output hit
  );
endinterface : cpdpr_reg_if

// ===== cpdpr_apb_slave.sv
// apb slave front end: decodes word addresses, answers with zero waits
// assumes the bank reports whether the index in rdIdx is mapped
`timescale 1ns/1ps
module cpdpr_apb_slave
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  cpdpr_reg_if.bus regs
);
  import cpdpr_pkg::*;

  logic [31:0] prdata_reg;
  logic aligned;
  logic mapped;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  always_comb
  begin
    aligned = (paddr[1:0] == 2'b00) && (paddr[31:6] == 26'h000_0000);
    regs.rdIdx = paddr[5:2];
    mapped = aligned && regs.hit;
  end

  // only the access phase writes, so a setup cycle never changes a bank register
  assign regs.wrEn = psel && penable && pwrite && mapped;
  assign regs.wrIdx = paddr[5:2];
  assign regs.wrData = pwdata[REG_W-1:0];
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_reg;

  // read data is caught in setup so it stands through the access phase
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      prdata_reg <= RDATA_NONE;
    else if (psel && !penable && !pwrite && mapped)
      prdata_reg <= {24'h00_0000, regs.rdData};
    else if (psel && !penable)
      prdata_reg <= RDATA_NONE;
  end
endmodule : cpdpr_apb_slave

// ===== cpdpr_pin_ctrl.sv
// serial port pin drivers: direction, float and clock gating
// assumes clock and data sources come from logic on clk
`timescale 1ns/1ps
module cpdpr_pin_ctrl
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic bitMaster,
  input wire logic frameMaster,
  input wire logic doutFloat,
  input wire logic keepClk,
  input wire logic powerDown,
  input wire logic frameOnGpOne,
  input wire logic bitClkGen,
  input wire logic frameClkGen,
  input wire logic doutGen,
  input wire logic doutValid,
  input wire logic bitClkI,
  input wire logic frameClkI,
  input wire logic gpOneI,
  output logic bitClkO,
  output logic bitClkOe,
  output logic frameClkO,
  output logic frameClkOe,
  output logic gpOneO,
  output logic gpOneOe,
  output logic doutO,
  output logic doutOe,
  output logic bitClkSync,
  output logic frameClkSync
);
  logic [1:0] bitSync_reg;
  logic [1:0] frameSync_reg;
  logic [1:0] gpSync_reg;
  logic clkRun;

  // clocks run in master mode unless powered down without keep-alive
  assign clkRun = !powerDown || keepClk; // RULE_17

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      bitClkO <= 1'b0;
      bitClkOe <= 1'b0;
      frameClkO <= 1'b0;
      frameClkOe <= 1'b0;
      gpOneO <= 1'b0;
      gpOneOe <= 1'b0;
    end
    else
    begin
      bitClkOe <= bitMaster; // RULE_14
      bitClkO <= bitMaster && clkRun && bitClkGen; // RULE_17
      frameClkOe <= frameMaster && !frameOnGpOne; // RULE_15
      gpOneOe <= frameMaster && frameOnGpOne; // RULE_15
      frameClkO <= frameMaster && clkRun && frameClkGen;
      gpOneO <= frameMaster && clkRun && frameClkGen;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      doutO <= 1'b0;
      doutOe <= 1'b1;
    end
    else
    begin
      doutO <= doutValid && doutGen;
      doutOe <= !doutFloat || doutValid; // RULE_16
    end
  end

  // pin inputs pass two flops before anything reads them
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      bitSync_reg <= 2'b00;
      frameSync_reg <= 2'b00;
      gpSync_reg <= 2'b00;
    end
    else
    begin
      bitSync_reg <= {bitSync_reg[0], bitClkI};
      frameSync_reg <= {frameSync_reg[0], frameClkI};
      gpSync_reg <= {gpSync_reg[0], gpOneI};
    end
  end

  // pin choice made after the flops so no raw pin feeds logic
  assign bitClkSync = bitSync_reg[1];
  assign frameClkSync = frameOnGpOne ? gpSync_reg[1] : frameSync_reg[1];
endmodule : cpdpr_pin_ctrl

// ===== cpdpr_top.sv
// register bank for pll fraction, codec datapath and serial port setup
// assumes an apb master on clk and serial sources from same-clock logic
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module cpdpr_top
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic powerDown,
  input wire logic frameOnGpOne,
  input wire logic bitClkGen,
  input wire logic frameClkGen,
  input wire logic doutGen,
  input wire logic doutValid,
  input wire logic bitClkI,
  input wire logic frameClkI,
  input wire logic gpOneI,
  output logic bitClkO,
  output logic bitClkOe,
  output logic frameClkO,
  output logic frameClkOe,
  output logic gpOneO,
  output logic gpOneOe,
  output logic doutO,
  output logic doutOe,
  output logic bitClkSync,
  output logic frameClkSync,
  output logic [cpdpr_pkg::FRAC_W-1:0] pllFraction,
  output logic fsRef44k,
  output logic adcDualRate,
  output logic dacDualRate,
  output logic leftTakesLeft,
  output logic leftTakesRight,
  output logic rightTakesRight,
  output logic rightTakesLeft,
  output logic effect3dEn
);
  import cpdpr_pkg::*;

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [REG_W-1:0] fracHigh_reg;
  logic [REG_W-1:0] fracLow_reg;
  logic [REG_W-1:0] datapath_reg;
  logic [REG_W-1:0] serialA_reg;
  logic [FRAC_W-1:0] fraction_reg;
  logic [3:0] route_reg;
  cpdpr_route_t leftRoute;
  cpdpr_route_t rightRoute;

  cpdpr_reg_if regBus ();

  // route decoding: bit 1 takes own channel, bit 0 takes the other
  function automatic logic [1:0] routeTakes(input cpdpr_route_t r);
    logic [1:0] t;
    t = 2'b00;
    case (r)
      ROUTE_MUTE: t = 2'b00;
      ROUTE_SAME: t = 2'b10;
      ROUTE_OTHER: t = 2'b01;
      ROUTE_MONO: t = 2'b11;
      default: t = 2'b00;
    endcase
    routeTakes = t;
  endfunction : routeTakes

  function automatic logic isWrite(input logic [IDX_W-1:0] idx);
    isWrite = regBus.wrEn && (regBus.wrIdx == idx);
  endfunction : isWrite

  // ---------------------------------------------------------------
  // bus front end
  // ---------------------------------------------------------------
  cpdpr_apb_slave u_apb
  (
    .clk(clk),
    .nrst(nrst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .regs(regBus.bus)
  );

  // ---------------------------------------------------------------
  // pll fraction
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      fracHigh_reg <= RST_FRAC_HIGH;
    else if (isWrite(IDX_FRAC_HIGH))
      fracHigh_reg <= regBus.wrData; // RULE_01 RULE_20
  end

  // low bits 1:0 are never stored, so they always read zero
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      fracLow_reg <= RST_FRAC_LOW;
    else if (isWrite(IDX_FRAC_LOW))
      fracLow_reg <= regBus.wrData & FRAC_LOW_MASK; // RULE_02 RULE_06
  end

  // the pll sees a new value only on the low write, so a lone high
  // write cannot leave a half-updated multiplier in use
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      fraction_reg <= RST_FRACTION;
    else if (isWrite(IDX_FRAC_LOW))
      fraction_reg <= {fracHigh_reg,
                       regBus.wrData[REG_W-1:FRAC_LOW_LSB]}; // RULE_05
  end

  assign pllFraction = fraction_reg;

  // ---------------------------------------------------------------
  // datapath and serial port
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      datapath_reg <= RST_DATAPATH;
    else if (isWrite(IDX_DATAPATH))
      datapath_reg <= regBus.wrData;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      serialA_reg <= RST_SERIAL_A;
    else if (isWrite(IDX_SERIAL_A))
      serialA_reg <= regBus.wrData;
  end

  assign fsRef44k = datapath_reg[DP_FSREF_BIT]; // RULE_07
  assign adcDualRate = datapath_reg[DP_ADC_DUAL_BIT]; // RULE_08
  assign dacDualRate = datapath_reg[DP_DAC_DUAL_BIT]; // RULE_09
  assign effect3dEn = serialA_reg[SP_EFFECT3D_BIT]; // RULE_18
  assign leftRoute =
    cpdpr_route_t'(datapath_reg[DP_LEFT_MSB:DP_LEFT_LSB]);
  assign rightRoute =
    cpdpr_route_t'(datapath_reg[DP_RIGHT_MSB:DP_RIGHT_LSB]);

  // decoded routing is registered so the mixer sees glitch-free selects
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      route_reg <= 4'h0;
    else
      route_reg <= {routeTakes(leftRoute),
                    routeTakes(rightRoute)}; // RULE_11 RULE_12
  end

  assign leftTakesLeft = route_reg[3];
  assign leftTakesRight = route_reg[2];
  assign rightTakesRight = route_reg[1];
  assign rightTakesLeft = route_reg[0];

  // ---------------------------------------------------------------
  // read back
  // ---------------------------------------------------------------
  always_comb
  begin
    regBus.hit = 1'b1;
    if (regBus.rdIdx == IDX_FRAC_HIGH)
      regBus.rdData = fracHigh_reg;
    else if (regBus.rdIdx == IDX_FRAC_LOW)
      regBus.rdData = fracLow_reg; // RULE_06
    else if (regBus.rdIdx == IDX_DATAPATH)
      regBus.rdData = datapath_reg;
    else if (regBus.rdIdx == IDX_SERIAL_A)
      regBus.rdData = serialA_reg;
    else
    begin
      regBus.hit = 1'b0;
      regBus.rdData = 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // serial pins
  // ---------------------------------------------------------------
  cpdpr_pin_ctrl u_pins
  (
    .clk(clk),
    .nrst(nrst),
    .bitMaster(serialA_reg[SP_BIT_MASTER_BIT]),
    .frameMaster(serialA_reg[SP_FRAME_MASTER_BIT]),
    .doutFloat(serialA_reg[SP_DOUT_FLOAT_BIT]),
    .keepClk(serialA_reg[SP_KEEP_CLK_BIT]),
    .powerDown(powerDown),
    .frameOnGpOne(frameOnGpOne),
    .bitClkGen(bitClkGen),
    .frameClkGen(frameClkGen),
    .doutGen(doutGen),
    .doutValid(doutValid),
    .bitClkI(bitClkI),
    .frameClkI(frameClkI),
    .gpOneI(gpOneI),
    .bitClkO(bitClkO),
    .bitClkOe(bitClkOe),
    .frameClkO(frameClkO),
    .frameClkOe(frameClkOe),
    .gpOneO(gpOneO),
    .gpOneOe(gpOneOe),
    .doutO(doutO),
    .doutOe(doutOe),
    .bitClkSync(bitClkSync),
    .frameClkSync(frameClkSync)
  );

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  a_frac_high_only: assert property ( // RULE_05
    isWrite(IDX_FRAC_HIGH) && !isWrite(IDX_FRAC_LOW)
    |=> $stable(pllFraction))
    else $error("fraction moved on a high-byte write");

  a_frac_low_apply: assert property ( // RULE_02
    isWrite(IDX_FRAC_LOW)
    |=> pllFraction[5:0] == $past(regBus.wrData[7:2]))
    else $error("fraction low bits not applied");

  // a back-to-back high then low write lands three cycles apart
  a_frac_high_apply: assert property ( // RULE_01
    isWrite(IDX_FRAC_HIGH) ##3 isWrite(IDX_FRAC_LOW)
    |=> pllFraction[13:6] == $past(regBus.wrData, 4))
    else $error("fraction high bits not applied");

  a_low_resv_zero: assert property ( // RULE_06
    psel && penable && !pwrite && paddr == byteAddr(IDX_FRAC_LOW)
    |-> prdata[1:0] == 2'b00)
    else $error("reserved fraction bits read nonzero");

  a_fsref_track: assert property ( // RULE_07
    isWrite(IDX_DATAPATH)
    |=> fsRef44k == $past(regBus.wrData[DP_FSREF_BIT]))
    else $error("reference rate select not taken");

  a_dual_rate: assert property ( // RULE_08
    isWrite(IDX_DATAPATH)
    |=> adcDualRate == $past(regBus.wrData[6])
        && dacDualRate == $past(regBus.wrData[5]))
    else $error("dual rate bits not taken");

  a_left_mono: assert property ( // RULE_11
    datapath_reg[4:3] == 2'b11 |=> leftTakesLeft && leftTakesRight)
    else $error("left mono mix not selected");

  a_right_swap: assert property ( // RULE_12
    datapath_reg[2:1] == 2'b10 |=> rightTakesLeft && !rightTakesRight)
    else $error("right swap route wrong");

  a_bit_dir: assert property ( // RULE_14
    ##1 serialA_reg[7] |=> bitClkOe)
    else $error("bit clock not driven in master mode");

  a_frame_dir: assert property ( // RULE_15
    !serialA_reg[6] |=> !frameClkOe && !gpOneOe)
    else $error("frame clock driven in slave mode");

  a_dout_float: assert property ( // RULE_16
    serialA_reg[5] && !doutValid |=> !doutOe)
    else $error("data output driven while idle and floating");

  a_dout_hold: assert property ( // RULE_16
    !serialA_reg[5] |=> doutOe)
    else $error("data output floated without float mode");

  a_clk_stop: assert property ( // RULE_17
    powerDown && !serialA_reg[4] |=> !bitClkO && !frameClkO)
    else $error("master clocks run through power-down");

  a_effect_3d: assert property ( // RULE_18
    isWrite(IDX_SERIAL_A)
    |=> effect3dEn == $past(regBus.wrData[SP_EFFECT3D_BIT]))
    else $error("3-D effect enable not taken");

  c_frac_pair: cover property (
    isWrite(IDX_FRAC_HIGH) ##3 isWrite(IDX_FRAC_LOW));
  c_master_keep: cover property (
    serialA_reg[7] && serialA_reg[4] && powerDown ##1 bitClkO);
  c_unmapped: cover property (pslverr);
  c_mono_both: cover property (
    leftTakesLeft && leftTakesRight && rightTakesLeft && rightTakesRight);
endmodule : cpdpr_top

// ===== cpdpr_host_model.sv
// host model: apb master that programs the codec register bank
// assumes one clock and a slave that raises pready by itself
`timescale 1ns/1ps
module cpdpr_host_model
(
  input wire logic clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  import cpdpr_pkg::*;
  bit hung;

  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0000_0000;
    pwdata = 32'h0000_0000;
    hung = 1'b0;
  end

  // ------------------------------------------------------------
  // bus cycles
  // ------------------------------------------------------------
  // request held from setup until pready is seen high at an edge
  task automatic xfer(input logic wr, input logic [31:0] a,
    input logic [31:0] wd, output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 64)
    begin
      n++;
      @(posedge clk);
    end
    if (pready !== 1'b1)
      hung = 1'b1;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines must not keep looking like the last request
    paddr <= ~a;
    pwdata <= ~wd;
  endtask : xfer

  task automatic regWr(input logic [IDX_W-1:0] idx,
    input logic [REG_W-1:0] d);
    logic [31:0] r;
    logic e;
    xfer(1'b1, {26'h000_0000, idx, 2'b00}, {24'h00_0000, d}, r, e);
  endtask : regWr

  task automatic setFraction(input logic [FRAC_W-1:0] f);
    logic [FRAC_W-1:0] v;
    v = (f > FRAC_MAX) ? FRAC_MAX : f;
    regWr(IDX_FRAC_HIGH, v[13:6]);
    regWr(IDX_FRAC_LOW, {v[5:0], 2'b00});
  endtask : setFraction

  task automatic setDatapath(input logic fs, input logic dual,
    input logic [1:0] l, input logic [1:0] r);
    regWr(IDX_DATAPATH, {fs, dual, dual, l, r, 1'b0});
  endtask : setDatapath

  // bit 3 cannot be skipped in a byte write, so it goes at reset value
  task automatic setSerial(input logic [3:0] m, input logic fx);
    regWr(IDX_SERIAL_A, {m, 1'b0, fx, 2'b00});
  endtask : setSerial
endmodule : cpdpr_host_model

// ===== tb_top.sv
// self-checking bench for the codec register bank
// assumes the host model as the only apb master
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    checks++; \
    if ((got) !== (exp)) \
    begin \
      fail_count++; \
      $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end
module tb_top;
  import cpdpr_pkg::*;
  logic clk, nrst, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic powerDown, frameOnGpOne, bitClkGen, frameClkGen, doutGen;
  logic doutValid, bitClkI, frameClkI, gpOneI;
  logic bitClkO, bitClkOe, frameClkO, frameClkOe, gpOneO, gpOneOe;
  logic doutO, doutOe, bitClkSync, frameClkSync, er;
  logic [FRAC_W-1:0] pllFraction, f, last;
  logic fsRef44k, adcDualRate, dacDualRate, effect3dEn;
  logic leftTakesLeft, leftTakesRight, rightTakesRight, rightTakesLeft;
  int fail_count = 0;
  int checks = 0;
  int i;
  logic [FRAC_W-1:0] fracTab [4] = '{14'h270F, 14'h0040, 14'h003F,
    14'h0000};
  logic [31:0] badAddr [3] = '{32'h0000_0024, 32'h0000_0015,
    32'h0000_0010};

  cpdpr_top dut (.clk(clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .powerDown(powerDown), .frameOnGpOne(frameOnGpOne),
    .bitClkGen(bitClkGen), .frameClkGen(frameClkGen),
    .doutGen(doutGen), .doutValid(doutValid), .bitClkI(bitClkI),
    .frameClkI(frameClkI), .gpOneI(gpOneI), .bitClkO(bitClkO),
    .bitClkOe(bitClkOe), .frameClkO(frameClkO),
    .frameClkOe(frameClkOe), .gpOneO(gpOneO), .gpOneOe(gpOneOe),
    .doutO(doutO), .doutOe(doutOe), .bitClkSync(bitClkSync),
    .frameClkSync(frameClkSync), .pllFraction(pllFraction),
    .fsRef44k(fsRef44k), .adcDualRate(adcDualRate),
    .dacDualRate(dacDualRate), .leftTakesLeft(leftTakesLeft),
    .leftTakesRight(leftTakesRight), .rightTakesRight(rightTakesRight),
    .rightTakesLeft(rightTakesLeft), .effect3dEn(effect3dEn));

  cpdpr_host_model host (.clk(clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic stop_test();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test

  task automatic rdChk(input logic [IDX_W-1:0] idx,
    input logic [REG_W-1:0] exp);
    logic [31:0] r;
    logic e;
    host.xfer(1'b0, {26'h000_0000, idx, 2'b00}, 32'h0000_0000, r, e);
    `CHK({e, r}, {1'b0, 24'h00_0000, exp})
  endtask : rdChk

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // a stuck bus or a runaway sequence still ends with a verdict
  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    stop_test();
  end

  always @(posedge clk)
    if (host.hung)
    begin
      fail_count++;
      stop_test();
    end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    nrst = 1'b0;
    {powerDown, frameOnGpOne, bitClkGen, frameClkGen, doutGen} = 5'h00;
    {doutValid, bitClkI, frameClkI, gpOneI} = 4'h0;
    last = RST_FRACTION;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    rdChk(IDX_FRAC_HIGH, RST_FRAC_HIGH);
    rdChk(IDX_FRAC_LOW, RST_FRAC_LOW);
    rdChk(IDX_DATAPATH, RST_DATAPATH);
    rdChk(IDX_SERIAL_A, RST_SERIAL_A);
    `CHK({doutOe, pllFraction}, {1'b1, RST_FRACTION})
    for (i = 0; i < 4; i++)
    begin
      f = fracTab[i];
      host.regWr(IDX_FRAC_HIGH, f[13:6]);
      repeat (2) @(posedge clk);
      `CHK(pllFraction, last)
      host.regWr(IDX_FRAC_LOW, {f[5:0], 2'b00});
      repeat (2) @(posedge clk);
      `CHK(pllFraction, f)
      rdChk(IDX_FRAC_HIGH, f[13:6]);
      last = f;
    end
    // low bits written high on purpose: they must still read zero
    host.regWr(IDX_FRAC_HIGH, 8'h00);
    host.xfer(1'b1, 32'h0000_0018, 32'h0000_00FF, rd, er);
    rdChk(IDX_FRAC_LOW, 8'hFC);
    `CHK(pllFraction, 14'h003F)
    for (i = 0; i < 3; i++)
    begin
      host.xfer(1'b0, badAddr[i], 32'h0000_0000, rd, er);
      `CHK({er, rd}, {1'b1, 32'h0000_0000})
      host.xfer(1'b1, badAddr[i], 32'h0000_00FF, rd, er);
      `CHK(er, 1'b1)
    end
    rdChk(IDX_FRAC_HIGH, 8'h00);
    for (i = 0; i < 16; i++)
    begin
      host.setDatapath(i[0], i[3], i[3:2], i[1:0]);
      repeat (2) @(posedge clk);
      `CHK({fsRef44k, adcDualRate}, {i[0], i[3]})
      `CHK(dacDualRate, i[3])
      `CHK({leftTakesLeft, leftTakesRight}, {i[2], i[3]})
      `CHK({rightTakesRight, rightTakesLeft}, {i[0], i[1]})
      rdChk(IDX_DATAPATH, {i[0], i[3], i[3], i[3:0], 1'b0});
    end
    @(posedge clk);
    {powerDown, bitClkGen, frameClkGen, doutGen} <= 4'hF;
    for (i = 0; i < 32; i++)
    begin
      @(posedge clk);
      frameOnGpOne <= i[4];
      host.setSerial(i[3:0], i[4]);
      repeat (3) @(posedge clk);
      `CHK(bitClkOe, i[3])
      `CHK({frameClkOe, gpOneOe}, {i[2] & !i[4], i[2] & i[4]})
      `CHK(doutOe, !i[1])
      `CHK({bitClkO, frameClkO | gpOneO}, {i[3], i[2]} & {2{i[0]}})
      `CHK(effect3dEn, i[4])
      rdChk(IDX_SERIAL_A, {i[3:0], 1'b0, i[4], 2'b00});
    end
    // last setting: both clocks master on pin one, keep-running set
    host.setSerial(4'hF, 1'b0);
    {doutValid, bitClkI, gpOneI} <= 3'b111;
    repeat (4) @(posedge clk);
    `CHK({doutO, doutOe, bitClkO, gpOneO}, 4'hF)
    `CHK({bitClkSync, frameClkSync}, 2'b11)
    powerDown <= 1'b0;
    bitClkGen <= 1'b0;
    frameOnGpOne <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK({bitClkO, gpOneO, frameClkSync}, 3'b010)
    `CHK({frameClkOe, gpOneOe}, 2'b10)
    host.setFraction(14'h1234);
    repeat (2) @(posedge clk);
    `CHK(pllFraction, 14'h1234)
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK(pllFraction, RST_FRACTION)
    nrst <= 1'b1;
    rdChk(IDX_FRAC_HIGH, RST_FRAC_HIGH);
    stop_test();
  end
endmodule : tb_top
